// file: srap_access_port.sv
// serial register access port: serial-clock engine, register store and pin drivers
`timescale 1ns/1ns
`default_nettype none
`include "srap_params.svh"
module srap_access_port #(
	parameter int          REG_DEPTH  = `SRAP_REG_DEPTH,
	parameter logic [14:0] HELD_BASE  = `SRAP_HELD_BASE,
	parameter int          HELD_BYTES = `SRAP_HELD_BYTES,
	parameter logic [14:0] LOAD_ADDR  = `SRAP_LOAD_ADDR,
	parameter int          LOAD_BIT   = `SRAP_LOAD_BIT
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    sclk,
	input  wire logic                    cs_n,
	input  wire logic                    sdio_in,
	output logic                         sdio_out,
	output logic                         sdio_oe,
	output logic                         sdo_out,
	output logic                         sdo_oe,
	output logic                         reg_wr_valid,
	output logic [14:0]                  reg_wr_addr,
	output logic [7:0]                   reg_wr_data,
	output logic [7:0]                   cfg_out,
	output logic [HELD_BYTES*8-1:0]      held_word
);
	localparam int AW = (REG_DEPTH > 1) ? $clog2(REG_DEPTH) : 1;
	localparam int HW = HELD_BYTES * 8;

	typedef struct packed {
		logic          rst_s1;
		logic          rst_s2;
		logic          wr_tgl;
		logic [14:0]   wr_addr;
		logic [7:0]    wr_data;
		logic          ld_tgl;
		logic [HW-1:0] held;
	} srap_rf_t;

	srap_link_if #(.HELD_W(HW)) lnk ();

	srap_pkg::srap_seq_t seq_ff;
	srap_pkg::srap_seq_t nxt_seq;
	srap_pkg::srap_drv_t drv_ff;
	srap_pkg::srap_drv_t nxt_drv;
	srap_rf_t            rf_ff;
	srap_rf_t            nxt_rf;
	logic [7:0]          mem_ff [REG_DEPTH];

	logic [15:0]   nsh;
	logic          lsb_first;
	logic          step_up;
	logic          sdo_mode;
	logic          byte_done;
	logic [7:0]    wbyte;
	logic [7:0]    rdb;
	logic          wr_en;
	logic [AW-1:0] wr_idx;
	logic [7:0]    wr_byte;
	logic          clr_all;

	function automatic logic [7:0] srap_rd(input logic [14:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (int'(a) < REG_DEPTH) begin
			v = mem_ff[a[AW-1:0]];
		end
		return v;
	endfunction

	// both mirrored copies are always written equal, so one of each pair is read
	assign lsb_first = mem_ff[0][`SRAP_CFG_LSB_BIT];
	assign step_up = mem_ff[0][`SRAP_CFG_STEP_BIT];
	assign sdo_mode = mem_ff[0][`SRAP_CFG_SDO_BIT];
	assign byte_done = (seq_ff.phase == srap_pkg::SRAP_PH_DATA) &&
		(seq_ff.cnt == `SRAP_BYTE_LAST);
	assign wbyte = lsb_first ? nsh[15:8] : nsh[7:0];
	// a process, so store writes re-evaluate the read byte, not only address moves
	always_comb begin
		rdb = srap_rd(seq_ff.addr);
	end

	// instruction and data sequencing; chip select high holds it at the start
	always_comb begin
		nxt_seq = seq_ff;
		// lsb first fills from the top so both orders end in the same layout
		nsh = lsb_first ? {sdio_in, seq_ff.sh[15:1]} : {seq_ff.sh[14:0], sdio_in};
		nxt_seq.sh = nsh;
		unique case (seq_ff.phase)
			srap_pkg::SRAP_PH_INSTR: begin
				nxt_seq.cnt = seq_ff.cnt + 4'h1;
				if (seq_ff.cnt == `SRAP_INSTR_LAST) begin
					nxt_seq.phase = srap_pkg::SRAP_PH_DATA;
					nxt_seq.cnt = 4'h0;
					nxt_seq.rw = nsh[`SRAP_RW_BIT];
					nxt_seq.addr = nsh[14:0];
				end
			end
			srap_pkg::SRAP_PH_DATA: begin
				if (seq_ff.cnt == `SRAP_BYTE_LAST) begin
					nxt_seq.cnt = 4'h0;
					// next byte of the same frame uses the generated address
					if (step_up) begin
						nxt_seq.addr = seq_ff.addr + 15'h0001;
					end else begin
						nxt_seq.addr = seq_ff.addr - 15'h0001;
					end
				end else begin
					nxt_seq.cnt = seq_ff.cnt + 4'h1;
				end
			end
		endcase
	end

	// a frame ends only by chip select; a partial byte at the cut is simply dropped
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			seq_ff <= '0;
		end else begin
			seq_ff <= nxt_seq;
		end
	end

	// register store updates and events toward the system clock
	always_comb begin
		logic [3:0] nib;
		logic [14:0] ha;
		nib = 4'h0;
		ha = 15'h0000;
		nxt_rf = rf_ff;
		wr_en = 1'b0;
		wr_idx = seq_ff.addr[AW-1:0];
		wr_byte = wbyte;
		clr_all = 1'b0;
		nxt_rf.rst_s1 = lnk.rst_req;
		nxt_rf.rst_s2 = rf_ff.rst_s1;
		if (rf_ff.rst_s2) begin
			// the store only clears on serial edges, so the clock must run after reset
			clr_all = 1'b1;
			nxt_rf.wr_tgl = 1'b0;
			nxt_rf.ld_tgl = 1'b0;
			nxt_rf.wr_addr = 15'h0000;
			nxt_rf.wr_data = 8'h00;
			nxt_rf.held = '0;
		end else if (byte_done && !seq_ff.rw) begin
			wr_en = int'(seq_ff.addr) < REG_DEPTH;
			if (seq_ff.addr == `SRAP_CFG_ADDR) begin
				// first nibble received, in msb-first weight, whatever the order
				nib = lsb_first ? {nsh[8], nsh[9], nsh[10], nsh[11]} : nsh[7:4];
				wr_byte = {nib, nib[0], nib[1], nib[2], nib[3]};
				if (nib[3]) begin
					// soft reset clears the store and itself
					clr_all = 1'b1;
					wr_byte = `SRAP_CFG_RESET;
				end
			end
			if (seq_ff.addr == LOAD_ADDR && wbyte[LOAD_BIT]) begin
				for (int i = 0; i < HELD_BYTES; i++) begin
					ha = HELD_BASE + 15'(i);
					nxt_rf.held[i*8 +: 8] = srap_rd(ha);
				end
				nxt_rf.ld_tgl = ~rf_ff.ld_tgl;
				wr_byte[LOAD_BIT] = 1'b0;
			end
			// held block is only a shadow until a load request
			if (!(int'(seq_ff.addr) >= int'(HELD_BASE) &&
				int'(seq_ff.addr) < int'(HELD_BASE) + HELD_BYTES)) begin
				nxt_rf.wr_tgl = ~rf_ff.wr_tgl;
				nxt_rf.wr_addr = seq_ff.addr;
				nxt_rf.wr_data = wr_byte;
			end
		end
	end

	always_ff @(posedge sclk) begin
		rf_ff <= nxt_rf;
	end

	always_ff @(posedge sclk) begin
		if (clr_all) begin
			for (int i = 0; i < REG_DEPTH; i++) begin
				mem_ff[i] <= `SRAP_CFG_RESET;
			end
		end else if (wr_en) begin
			mem_ff[wr_idx] <= wr_byte;
		end
	end

	// read data driver on the falling edge, half a period after the count moves
	always_comb begin
		logic drive;
		drive = (seq_ff.phase == srap_pkg::SRAP_PH_DATA) && seq_ff.rw;
		nxt_drv.bit_q = lsb_first ? rdb[seq_ff.cnt[2:0]] :
			rdb[3'h7 - seq_ff.cnt[2:0]];
		nxt_drv.sdio_en = drive && !sdo_mode;
		nxt_drv.sdo_en = drive && sdo_mode;
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			drv_ff <= '0;
		end else begin
			drv_ff <= nxt_drv;
		end
	end

	assign sdio_out = drv_ff.bit_q;
	assign sdio_oe = drv_ff.sdio_en;
	assign sdo_out = drv_ff.bit_q;
	assign sdo_oe = drv_ff.sdo_en;

	assign lnk.wr_tgl = rf_ff.wr_tgl;
	assign lnk.wr_addr = rf_ff.wr_addr;
	assign lnk.wr_data = rf_ff.wr_data;
	assign lnk.ld_tgl = rf_ff.ld_tgl;
	assign lnk.held = rf_ff.held;
	assign lnk.rst_seen = rf_ff.rst_s2;

	srap_mclk_bridge #(.HELD_W(HW)) u_bridge (
		.mclk         (mclk),
		.rst          (rst),
		.lnk          (lnk),
		.reg_wr_valid (reg_wr_valid),
		.reg_wr_addr  (reg_wr_addr),
		.reg_wr_data  (reg_wr_data),
		.cfg_out      (cfg_out),
		.held_word    (held_word)
	);
endmodule
`default_nettype wire

// file: srap_params.svh
// constants for the serial register access port
`ifndef SRAP_PARAMS_SVH
`define SRAP_PARAMS_SVH

`define SRAP_CFG_ADDR      15'h0000
`define SRAP_CFG_RESET     8'h00
`define SRAP_CFG_SRST_BIT  7
`define SRAP_CFG_LSB_BIT   6
`define SRAP_CFG_STEP_BIT  5
`define SRAP_CFG_SDO_BIT   4
`define SRAP_INSTR_LAST    4'hF
`define SRAP_BYTE_LAST     4'h7
`define SRAP_RW_BIT        15
`define SRAP_HELD_BASE     15'h0010
`define SRAP_HELD_BYTES    8
`define SRAP_LOAD_ADDR     15'h0008
`define SRAP_LOAD_BIT      0
`define SRAP_REG_DEPTH     64

`endif

// file: srap_pkg.sv
// types shared by the serial register access port
package srap_pkg;

	typedef enum logic {
		SRAP_PH_INSTR,
		SRAP_PH_DATA
	} srap_phase_t;

	typedef struct packed {
		srap_phase_t phase;
		logic [3:0]  cnt;
		logic [15:0] sh;
		logic        rw;
		logic [14:0] addr;
	} srap_seq_t;

	typedef struct packed {
		logic bit_q;
		logic sdio_en;
		logic sdo_en;
	} srap_drv_t;

endpackage

// file: srap_link_if.sv
// crossing signals between the serial-clock engine and the system-clock side
`timescale 1ns/1ns
`default_nettype none
interface srap_link_if #(
	parameter int HELD_W = 64
);
	logic              wr_tgl;
	logic [14:0]       wr_addr;
	logic [7:0]        wr_data;
	logic              ld_tgl;
	logic [HELD_W-1:0] held;
	logic              rst_req;
	logic              rst_seen;

	modport eng (
		output wr_tgl,
		output wr_addr,
		output wr_data,
		output ld_tgl,
		output held,
		output rst_seen,
		input  rst_req
	);

	modport brg (
		input  wr_tgl,
		input  wr_addr,
		input  wr_data,
		input  ld_tgl,
		input  held,
		input  rst_seen,
		output rst_req
	);
endinterface
`default_nettype wire

// file: srap_mclk_bridge.sv
// system-clock side: reset request, write events and held word capture
`timescale 1ns/1ns
`default_nettype none
`include "srap_params.svh"
module srap_mclk_bridge #(
	parameter int HELD_W = 64
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	srap_link_if.brg               lnk,
	output logic                   reg_wr_valid,
	output logic [14:0]            reg_wr_addr,
	output logic [7:0]             reg_wr_data,
	output logic [7:0]             cfg_out,
	output logic [HELD_W-1:0]      held_word
);
	typedef struct packed {
		logic              pend;
		logic              ack_s1;
		logic              ack_s2;
		logic              wt_s1;
		logic              wt_s2;
		logic              wt_s3;
		logic              lt_s1;
		logic              lt_s2;
		logic              lt_s3;
		logic              wr_valid;
		logic [14:0]       wr_addr;
		logic [7:0]        wr_data;
		logic [7:0]        cfg;
		logic [HELD_W-1:0] held;
	} srap_brg_t;

	srap_brg_t b_ff;
	srap_brg_t nxt_b;

	always_comb begin
		nxt_b = b_ff;
		nxt_b.ack_s1 = lnk.rst_seen;
		nxt_b.ack_s2 = b_ff.ack_s1;
		nxt_b.wt_s1 = lnk.wr_tgl;
		nxt_b.wt_s2 = b_ff.wt_s1;
		nxt_b.wt_s3 = b_ff.wt_s2;
		nxt_b.lt_s1 = lnk.ld_tgl;
		nxt_b.lt_s2 = b_ff.lt_s1;
		nxt_b.lt_s3 = b_ff.lt_s2;
		nxt_b.wr_valid = 1'b0;
		// request stays up until the serial side has seen it
		if (b_ff.ack_s2) begin
			nxt_b.pend = 1'b0;
		end
		// toggles are unsettled until the serial side clears, so no events while the reset request is pending
		if (!b_ff.pend && (b_ff.wt_s2 != b_ff.wt_s3)) begin
			nxt_b.wr_valid = 1'b1;
			nxt_b.wr_addr = lnk.wr_addr;
			nxt_b.wr_data = lnk.wr_data;
			if (lnk.wr_addr == `SRAP_CFG_ADDR) begin
				nxt_b.cfg = lnk.wr_data;
			end
		end
		if (!b_ff.pend && (b_ff.lt_s2 != b_ff.lt_s3)) begin
			nxt_b.held = lnk.held;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			b_ff <= '0;
			b_ff.pend <= 1'b1;
			b_ff.cfg <= `SRAP_CFG_RESET;
		end else begin
			b_ff <= nxt_b;
		end
	end

	assign lnk.rst_req = b_ff.pend;
	assign reg_wr_valid = b_ff.wr_valid;
	assign reg_wr_addr = b_ff.wr_addr;
	assign reg_wr_data = b_ff.wr_data;
	assign cfg_out = b_ff.cfg;
	assign held_word = b_ff.held;
endmodule
`default_nettype wire

// file: srap_access_port_asserts.sv
// assertion checker for the serial register access port
`timescale 1ns/1ns
`default_nettype none
module srap_chk #(
	parameter int          HELD_BYTES = 8,
	parameter logic [14:0] LOAD_ADDR  = 15'h0008
) (
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire logic                    sclk,
	input wire logic                    cs_n,
	input wire logic                    sdio_in,
	input wire logic                    sdio_out,
	input wire logic                    sdio_oe,
	input wire logic                    sdo_out,
	input wire logic                    sdo_oe,
	input wire logic                    reg_wr_valid,
	input wire logic [14:0]             reg_wr_addr,
	input wire logic [7:0]              reg_wr_data,
	input wire logic [7:0]              cfg_out,
	input wire logic [HELD_BYTES*8-1:0] held_word
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence load_ev;
		reg_wr_valid && reg_wr_addr == LOAD_ADDR;
	endsequence
	oe_idle_a: assert property (cs_n && $past(cs_n) |-> !sdio_oe && !sdo_oe)
		else $error("driver on while deselected");
	oe_excl_a: assert property (!(sdio_oe && sdo_oe))
		else $error("both drivers on");
	sdo_mode_a: assert property (sdo_oe |-> cfg_out[4])
		else $error("separate line used in 3-wire mode");
	sdio_mode_a: assert property (sdio_oe |-> !cfg_out[4])
		else $error("shared line driven in 4-wire mode");
	oe_start_a: assert property ($rose(sdio_oe) || $rose(sdo_oe) |-> !cs_n)
		else $error("driver raised outside a frame");
	wr_pulse_a: assert property (reg_wr_valid |=> !reg_wr_valid)
		else $error("write event longer than one cycle");
	wr_stable_a: assert property (reg_wr_valid |=> $stable({reg_wr_addr, reg_wr_data}) [*4])
		else $error("write event fields moved");
	cfg_mirror_a: assert property (cfg_out[3:0] == {cfg_out[4], cfg_out[5], cfg_out[6], cfg_out[7]})
		else $error("config halves not mirrored");
	cfg_update_a: assert property ($changed(cfg_out) |->
		reg_wr_addr == 15'h0 && (reg_wr_valid || $past(reg_wr_valid)))
		else $error("config changed without a write");
	held_load_a: assert property ($changed(held_word) |-> ##[0:12] load_ev)
		else $error("held word changed without load request");
endmodule
bind srap_access_port srap_chk #(.HELD_BYTES(HELD_BYTES), .LOAD_ADDR(LOAD_ADDR)) u_chk (
	.mclk, .rst, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe, .sdo_out, .sdo_oe,
	.reg_wr_valid, .reg_wr_addr, .reg_wr_data, .cfg_out, .held_word);
`default_nettype wire

// file: srap_spi_master.sv
// controller model that frames register transfers on the serial port
`timescale 1ns/1ns
`default_nettype none
module srap_spi_master (
	output logic      sclk,
	output logic      cs_n,
	output wire logic sdio_in,
	input  wire logic sdio_out,
	input  wire logic sdio_oe,
	input  wire logic sdo_out,
	input  wire logic sdo_oe
);
	logic drv = 1'b0;
	logic lsb = 1'b0;
	logic four = 1'b0;
	int   hp = 16;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		// a rising select at start puts the port's drivers into their idle state
		#1;
		cs_n = 1'b1;
	end
	// released line carries the controller's drive value drv, which it toggles bit by bit in read frames
	assign sdio_in = sdio_oe ? sdio_out : drv;
	task automatic clocks(input int n);
		repeat (n) begin
			#hp sclk = 1'b1;
			#hp sclk = 1'b0;
		end
	endtask
	task automatic frame(input logic [15:0] ins, input int n, input logic [7:0] wd [8],
		output logic [7:0] rd [8], input int cut);
		int   j;
		int   k;
		cs_n = 1'b0;
		#hp;
		for (int t = 0; t < 16 + 8 * n && t != cut; t++) begin
			j = (t - 16) / 8;
			k = lsb ? (t - 16) % 8 : 7 - (t - 16) % 8;
			if (t < 16) drv = lsb ? ins[t] : ins[15 - t];
			else drv = ins[15] ? ~drv : wd[j][k];
			#hp sclk = 1'b1;
			// an undriven line reads as the inverse, so a silent device never matches
			if (t >= 16) rd[j][k] = four ? (sdo_oe ? sdo_out : ~sdo_out) :
				(sdio_oe ? sdio_in : ~sdio_out);
			#hp sclk = 1'b0;
		end
		#hp cs_n = 1'b1;
		drv = ~drv;
		#(2 * hp);
	endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for the serial register access port
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	wire logic   sclk, cs_n, sdio_in;
	logic        sdio_out, sdio_oe, sdo_out, sdo_oe, reg_wr_valid;
	logic [14:0] reg_wr_addr;
	logic [7:0]  reg_wr_data, cfg_out;
	logic [63:0] held_word, hexp;
	logic [7:0]  d [8];
	logic [7:0]  rd [8];
	logic [31:0] seed = 32'h7B72;
	int          err_count = 0;
	int          compares = 0;
	int          cyc = 0;
	srap_access_port DUT (.mclk, .rst, .sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe, .sdo_out,
		.sdo_oe, .reg_wr_valid, .reg_wr_addr, .reg_wr_data, .cfg_out, .held_word);
	srap_spi_master mdl (.sclk, .cs_n, .sdio_in, .sdio_out, .sdio_oe, .sdo_out, .sdo_oe);
	initial begin
		forever #5 mclk = ~mclk;
	end
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] cfg_of(input logic [3:0] n);
		return {n, n[0], n[1], n[2], n[3]};
	endfunction
	task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("mismatch t=%0t read %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_out(input logic [63:0] g, input logic [63:0] e);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("mismatch t=%0t output %h exp %h", $time, g, e);
		end
	endtask
	task print_verdict;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			print_verdict;
		end
	end
	initial begin
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		mdl.clocks(4);
		repeat (8) @(negedge mclk);
		mdl.frame(16'h8000, 1, d, rd, 99);
		chk_rd(rd[0], cfg_of(4'h0));
		for (int i = 0; i < 3; i++) d[i] = xs();
		mdl.frame(16'h0022, 3, d, rd, 99);
		chk_out(reg_wr_addr, 15'h0020);
		chk_out(reg_wr_data, d[2]);
		mdl.frame(16'h8021, 2, d, rd, 99);
		chk_rd(rd[0], d[1]);
		chk_rd(rd[1], d[2]);
		// abandoned write must leave the byte untouched
		d[0] = ~d[1];
		mdl.frame(16'h0021, 1, d, rd, 20);
		mdl.frame(16'h8021, 1, d, rd, 99);
		chk_rd(rd[0], d[1]);
		d[0] = 8'h70;
		mdl.frame(16'h0000, 1, d, rd, 99);
		repeat (4) @(negedge mclk);
		chk_out(cfg_out, cfg_of(4'h7));
		mdl.lsb = 1'b1;
		mdl.four = 1'b1;
		for (int i = 0; i < 8; i++) d[i] = xs();
		mdl.frame(16'h0010, 8, d, rd, 999);
		repeat (4) @(negedge mclk);
		chk_out(held_word, 64'h0);
		mdl.frame(16'h8011, 2, d, rd, 999);
		chk_rd(rd[0], d[1]);
		chk_rd(rd[1], d[2]);
		hexp = {d[7], d[6], d[5], d[4], d[3], d[2], d[1], d[0]};
		d[0] = 8'h01;
		mdl.frame(16'h0008, 1, d, rd, 999);
		repeat (4) @(negedge mclk);
		chk_out(held_word, hexp);
		// first bit received lands on the soft reset pair in lsb-first order
		d[0] = 8'h01;
		mdl.frame(16'h0000, 1, d, rd, 999);
		mdl.lsb = 1'b0;
		mdl.four = 1'b0;
		repeat (4) @(negedge mclk);
		chk_out(cfg_out, cfg_of(4'h0));
		mdl.frame(16'h8011, 1, d, rd, 999);
		chk_rd(rd[0], 8'h00);
		print_verdict;
	end
endmodule
`default_nettype wire
